// >>> rtl/voice_pkg.sv
// Shared constants for the voice capture subsystem
package voice_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int PCM_HZ = 16_000;
  localparam int TICK_CYC = CLK_HZ / PCM_HZ;
  localparam int GEN_HALF = 12;
  localparam int EXT_IDLE = 64;
  localparam int SAD_RUN = 8;
  localparam int PDM_SHIFT = 8;
  localparam int GAIN_FRAC = 8;
  localparam int I2S_SLOT_LAST = 16;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GAIN = 8'h04;
  localparam logic [7:0] OFF_THR = 8'h08;
  localparam logic [7:0] OFF_BASE = 8'h0c;
  localparam logic [7:0] OFF_LEN = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_PTR = 8'h18;
  localparam int B_LEFT = 0;
  localparam int B_RIGHT = 1;
  localparam int B_STEREO = 2;
  localparam int B_SRC_I2S = 3;
  localparam int B_PASS = 4;
  localparam int B_DOWN = 5;
  localparam int B_SCALE = 6;
  localparam int B_SAD_EN = 8;
  localparam int B_SAD_SEL = 9;
  localparam int B_DMA_EN = 10;
  localparam int B_TX_EN = 11;
  localparam int B_WAKE = 2;
  localparam int B_EXT = 3;
  localparam logic [13:0] GAIN_RST = 14'h0100;
  // 34.5 dB in Q6.8
  localparam logic [13:0] GAIN_MAX = 14'h3517;
  localparam logic [15:0] THR_RST = 16'h0400;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
endpackage

// >>> rtl/chan_if.sv
// Sample path between the capture front end and one converter channel
`timescale 1ns/1ps
interface chan_if;
  logic tick;
  logic pdm_valid;
  logic pdm_bit;
  logic i2s_valid;
  logic [15:0] i2s_word;
  logic out_valid;
  logic [15:0] out_pcm;
  modport conv (input tick, pdm_valid, pdm_bit, i2s_valid, i2s_word,
                output out_valid, out_pcm);
  modport src (output tick, pdm_valid, pdm_bit, i2s_valid, i2s_word,
               input out_valid, out_pcm);
endinterface

// >>> rtl/density_to_pcm_converter.sv
// One channel: density-to-PCM decimation, I2S scaling, down-sampling and gain
`timescale 1ns/1ps
module density_to_pcm_converter (
  input wire logic pclk,
  input wire logic presetn,
  chan_if.conv ch,
  input wire logic enable,
  input wire logic use_i2s,
  input wire logic downsample,
  input wire logic [1:0] scale,
  input wire logic [13:0] gain
);
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh0000_7fff) begin
      return 16'sh7fff;
    end
    if (v < -32'sh0000_8000) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction

  logic signed [15:0] acc_ff, raw_ff, half_ff;
  logic raw_v_ff, odd_ff, out_valid_ff;
  logic [15:0] out_ff;

  wire signed [31:0] pdm_w = 32'(acc_ff) <<< voice_pkg::PDM_SHIFT;
  wire signed [31:0] i2s_w = 32'(signed'(ch.i2s_word)) <<< scale;
  wire signed [15:0] i2s_s = sat16(i2s_w);
  wire signed [31:0] pair = (32'(half_ff) + 32'(i2s_s)) >>> 1;
  wire signed [31:0] gain_s = 32'(signed'({2'h0, gain}));
  wire signed [31:0] prod = (32'(raw_ff) * gain_s) >>> voice_pkg::GAIN_FRAC;
  wire signed [15:0] step = ch.pdm_bit ? 16'sh0001 : 16'shffff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 16'sh0000;
      raw_ff <= 16'sh0000;
      half_ff <= 16'sh0000;
      raw_v_ff <= 1'b0;
      odd_ff <= 1'b0;
      out_valid_ff <= 1'b0;
      out_ff <= 16'h0000;
    end else begin
      raw_v_ff <= 1'b0;
      out_valid_ff <= enable & raw_v_ff;
      if (raw_v_ff) begin
        out_ff <= sat16(prod);
      end
      if (!enable) begin
        acc_ff <= 16'sh0000;
        odd_ff <= 1'b0;
      end else if (!use_i2s) begin
        // One box window per 16 kHz tick gives one 16-bit sample
        if (ch.tick) begin
          raw_ff <= sat16(pdm_w);
          raw_v_ff <= 1'b1;
          acc_ff <= 16'sh0000;
        end else if (ch.pdm_valid) begin
          acc_ff <= acc_ff + step;
        end
      end else if (ch.i2s_valid) begin
        if (!downsample) begin
          raw_ff <= i2s_s;
          raw_v_ff <= 1'b1;
        end else if (!odd_ff) begin
          half_ff <= i2s_s;
          odd_ff <= 1'b1;
        end else begin
          raw_ff <= sat16(pair);
          raw_v_ff <= 1'b1;
          odd_ff <= 1'b0;
        end
      end
    end
  end

  assign ch.out_valid = out_valid_ff;
  assign ch.out_pcm = out_ff;

  pair_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && use_i2s && downsample && ch.i2s_valid && !odd_ff)
      |=> !raw_v_ff ##1 !out_valid_ff)
    else $error("down-sampling emitted a sample on the first of a pair");
  gain_lat_a: assert property (@(posedge pclk) disable iff (!presetn)
    (raw_v_ff && enable) |=> out_valid_ff && out_ff == $past(sat16(prod)))
    else $error("gain stage result missing or wrong");
endmodule

// >>> rtl/voice_capture_subsystem.sv
// Voice capture top: pins, APB registers, FIFOs, DMA, detector, I2S slave
//
// Overview of operation
// - Software may enable the left or right converter alone for one microphone.
// - Stereo setting runs left and right converters together.
// - Each converter yields 16-bit PCM samples at 16 kHz, or 32 kHz from I2S without down-sampling.
// - I2S microphone port drives bit clock and word select, returns 16-bit PCM.
// - I2S samples pass unchanged or scaled by 2, 4 or 8.
// - Optional down-sampling halves I2S PCM from 32 kHz to 16 kHz.
// - Configurable digital gain up to 34.5 dB on PCM samples.
// - Enabled detector takes samples from the left or right channel.
// - Detector recognises sustained voice energy and raises a wake-up.
// - Pass-through forwards the external clock input to the microphone clock.
// - Pass-through forwards microphone data to the external processor unchanged.
// - Mode and external clock activity decide who drives the microphone clock.
// - Each microphone channel has its own sample FIFO.
// - DMA moves FIFO samples to SRAM over an AHB-Lite master.
// - Configuration registers are reached through an APB slave.
// - I2S slave streams SRAM samples to an external master clocking it.
// - System DMA channel 0 feeds the I2S slave port.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module voice_capture_subsystem #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic passthru_clock_in,
  input wire logic mic_data_in,
  output logic mic_clock_out,
  output logic passthru_data_out,
  output logic i2s_mic_bclk_out,
  output logic i2s_mic_ws_out,
  input wire logic i2s_mic_sd_in,
  input wire logic i2s_sck_in,
  input wire logic i2s_ws_in,
  output logic i2s_sd_out,
  output logic system_dma_ch0_req,
  input wire logic system_dma_ch0_valid,
  input wire logic [15:0] system_dma_ch0_data,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [2:0] hburst,
  output logic [31:0] hwdata,
  input wire logic hready,
  output logic wake_out
);
  localparam int PW = $clog2(FIFO_DEPTH);
  typedef enum logic [1:0] {D_IDLE, D_ADDR, D_DATA} dma_state_t;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: 0 ext clock, 1 mic data, 2 i2s mic data, 3 sck, 4 ws
  logic [4:0] s1_ff, s2_ff, prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
      prev_ff <= 5'h00;
    end else begin
      s1_ff <= {i2s_ws_in, i2s_sck_in, i2s_mic_sd_in, mic_data_in, passthru_clock_in};
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [11:0] ctrl_ff;
  logic [13:0] gain_ff;
  logic [15:0] thr_ff, len_ff, ptr_ff;
  logic [31:0] base_ff;
  logic [1:0] ovf_ff;
  logic wake_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic ext_active;

  wire [7:0] a = paddr[7:0];
  wire acc_req = psel & penable;
  wire done = acc_req & pready_ff;
  wire in_map = paddr[11:8] == 4'h0 && a[1:0] == 2'h0 && a <= voice_pkg::OFF_PTR;
  wire wr = done & pwrite & in_map;
  wire wr_stat = wr && a == voice_pkg::OFF_STAT;
  wire [3:0] stat = {ext_active, wake_ff, ovf_ff};
  wire [31:0] rd_word = a == voice_pkg::OFF_CTRL ? {20'h0, ctrl_ff} :
                        a == voice_pkg::OFF_GAIN ? {18'h0, gain_ff} :
                        a == voice_pkg::OFF_THR ? {16'h0, thr_ff} :
                        a == voice_pkg::OFF_BASE ? base_ff :
                        a == voice_pkg::OFF_LEN ? {16'h0, len_ff} :
                        a == voice_pkg::OFF_STAT ? {28'h0, stat} :
                        a == voice_pkg::OFF_PTR ? {16'h0, ptr_ff} : 32'h0;
  wire [13:0] gain_wr = pwdata[13:0] > voice_pkg::GAIN_MAX ? voice_pkg::GAIN_MAX : pwdata[13:0];

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      ctrl_ff <= 12'h000;
      gain_ff <= voice_pkg::GAIN_RST;
      thr_ff <= voice_pkg::THR_RST;
      base_ff <= 32'h0;
      len_ff <= 16'h0;
    end else begin
      pready_ff <= acc_req & ~pready_ff;
      if (acc_req & ~pready_ff) begin
        prdata_ff <= (pwrite || !in_map) ? 32'h0 : rd_word;
        pslverr_ff <= !in_map;
      end
      if (wr) begin
        case (a)
          voice_pkg::OFF_CTRL: ctrl_ff <= pwdata[11:0];
          voice_pkg::OFF_GAIN: gain_ff <= gain_wr;
          voice_pkg::OFF_THR: thr_ff <= pwdata[15:0];
          voice_pkg::OFF_BASE: base_ff <= {pwdata[31:2], 2'h0};
          voice_pkg::OFF_LEN: len_ff <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Own link clock, external clock detection, pass-through
  logic [4:0] half_ff;
  logic [11:0] tick_ff;
  logic [6:0] ext_idle_ff;
  logic gen_clk_ff, mic_clk_ff, pass_d_ff;
  wire half_end = half_ff == 5'(voice_pkg::GEN_HALF - 1);
  wire tick = tick_ff == 12'(voice_pkg::TICK_CYC - 1);
  wire gen_rise = half_end & ~gen_clk_ff;
  wire gen_fall = half_end & gen_clk_ff;
  wire ext_edge = s2_ff[0] ^ prev_ff[0];
  assign ext_active = ext_idle_ff < 7'(voice_pkg::EXT_IDLE);
  wire use_ext = ctrl_ff[voice_pkg::B_PASS] & ext_active;
  wire smp_rise = use_ext ? (s2_ff[0] & ~prev_ff[0]) : gen_rise;
  wire smp_fall = use_ext ? (~s2_ff[0] & prev_ff[0]) : gen_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 5'h0;
      tick_ff <= 12'h0;
      ext_idle_ff <= 7'(voice_pkg::EXT_IDLE);
      gen_clk_ff <= 1'b0;
      mic_clk_ff <= 1'b0;
      pass_d_ff <= 1'b0;
    end else begin
      half_ff <= half_end ? 5'h0 : half_ff + 5'h1;
      tick_ff <= tick ? 12'h0 : tick_ff + 12'h1;
      gen_clk_ff <= gen_clk_ff ^ half_end;
      if (ext_edge) begin
        ext_idle_ff <= 7'h0;
      end else if (ext_active) begin
        ext_idle_ff <= ext_idle_ff + 7'h1;
      end
      mic_clk_ff <= use_ext ? s2_ff[0] : gen_clk_ff;
      pass_d_ff <= ctrl_ff[voice_pkg::B_PASS] & s2_ff[1];
    end
  end
  assign mic_clock_out = mic_clk_ff;
  assign passthru_data_out = pass_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // I2S microphone master: 32 bit clocks per slot, 16 data bits after one delay bit
  logic [5:0] bit_ff;
  logic ws_ff;
  logic [15:0] mic_sh_ff;
  wire [4:0] pos = bit_ff[4:0];
  wire i2s_take = gen_rise && pos >= 5'h1 && pos <= 5'(voice_pkg::I2S_SLOT_LAST);
  wire i2s_done = gen_rise && pos == 5'(voice_pkg::I2S_SLOT_LAST);
  wire [15:0] i2s_word = {mic_sh_ff[14:0], s2_ff[2]};
  wire [5:0] nxt_bit = bit_ff + 6'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_ff <= 6'h0;
      ws_ff <= 1'b0;
      mic_sh_ff <= 16'h0;
    end else begin
      if (gen_fall) begin
        bit_ff <= nxt_bit;
        ws_ff <= nxt_bit[5];
      end
      if (i2s_take) begin
        mic_sh_ff <= i2s_word;
      end
    end
  end
  assign i2s_mic_bclk_out = gen_clk_ff;
  assign i2s_mic_ws_out = ws_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Converters and per-channel FIFOs (0 left, 1 right)
  chan_if ch[2] ();
  logic [1:0] ov, full, ne, pop, en;
  logic [15:0] opcm [2];
  logic [15:0] mem_ff [2][FIFO_DEPTH];
  logic [PW-1:0] wp_ff [2];
  logic [PW-1:0] rp_ff [2];
  logic [PW:0] cnt_ff [2];

  assign en[0] = ctrl_ff[voice_pkg::B_LEFT] | ctrl_ff[voice_pkg::B_STEREO];
  assign en[1] = ctrl_ff[voice_pkg::B_RIGHT] | ctrl_ff[voice_pkg::B_STEREO];

  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign ch[i].tick = tick;
    assign ch[i].pdm_valid = i == 0 ? smp_rise : smp_fall;
    assign ch[i].pdm_bit = s2_ff[1];
    assign ch[i].i2s_valid = i2s_done && bit_ff[5] == 1'(i);
    assign ch[i].i2s_word = i2s_word;
    assign ov[i] = ch[i].out_valid;
    assign opcm[i] = ch[i].out_pcm;
    assign full[i] = cnt_ff[i] == (PW+1)'(FIFO_DEPTH);
    assign ne[i] = cnt_ff[i] != '0;
    wire push = ov[i] & ~full[i];
    density_to_pcm_converter u_conv (
      .pclk(pclk),
      .presetn(presetn),
      .ch(ch[i]),
      .enable(en[i]),
      .use_i2s(ctrl_ff[voice_pkg::B_SRC_I2S]),
      .downsample(ctrl_ff[voice_pkg::B_DOWN]),
      .scale(ctrl_ff[voice_pkg::B_SCALE +: 2]),
      .gain(gain_ff)
    );
    always_ff @(posedge pclk) begin
      if (push) begin
        mem_ff[i][wp_ff[i]] <= opcm[i];
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wp_ff[i] <= '0;
        rp_ff[i] <= '0;
        cnt_ff[i] <= '0;
        ovf_ff[i] <= 1'b0;
      end else begin
        wp_ff[i] <= wp_ff[i] + PW'(push);
        rp_ff[i] <= rp_ff[i] + PW'(pop[i]);
        cnt_ff[i] <= cnt_ff[i] + (PW+1)'(push) - (PW+1)'(pop[i]);
        // Set wins over a simultaneous write-one-to-clear
        if (ov[i] & full[i]) begin
          ovf_ff[i] <= 1'b1;
        end else if (wr_stat & pwdata[i]) begin
          ovf_ff[i] <= 1'b0;
        end
      end
    end
    ovf_set_a: assert property ((ov[i] && full[i]) |=> ovf_ff[i])
      else $error("overflow flag not set on dropped sample");
    drop_keep_a: assert property ((ov[i] && full[i] && !pop[i]) |=> full[i])
      else $error("full FIFO changed level on dropped sample");
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA engine: one single-word AHB-Lite write per sample, alternating channels
  dma_state_t dst_ff;
  logic rr_ff, hwrite_ff;
  logic [31:0] haddr_ff, hwdata_ff, hold_w_ff;
  logic [1:0] htrans_ff;
  logic [2:0] hsize_ff, hburst_ff;
  wire pick = ne[1] & (~ne[0] | rr_ff);
  wire go = dst_ff == D_IDLE && ctrl_ff[voice_pkg::B_DMA_EN] && ne != 2'h0;
  wire [15:0] nxt_ptr = ptr_ff + 16'h1;
  assign pop[0] = go & ~pick;
  assign pop[1] = go & pick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_ff <= D_IDLE;
      rr_ff <= 1'b0;
      ptr_ff <= 16'h0;
      haddr_ff <= 32'h0;
      htrans_ff <= voice_pkg::HTRANS_IDLE;
      hwrite_ff <= 1'b0;
      hsize_ff <= voice_pkg::HSIZE_WORD;
      hburst_ff <= voice_pkg::HBURST_SINGLE;
      hwdata_ff <= 32'h0;
      hold_w_ff <= 32'h0;
    end else begin
      case (dst_ff)
        D_IDLE: if (go) begin
          hold_w_ff <= {15'h0, pick, mem_ff[pick][rp_ff[pick]]};
          haddr_ff <= base_ff + {14'h0, ptr_ff, 2'h0};
          htrans_ff <= voice_pkg::HTRANS_NONSEQ;
          hwrite_ff <= 1'b1;
          hsize_ff <= voice_pkg::HSIZE_WORD;
          hburst_ff <= voice_pkg::HBURST_SINGLE;
          rr_ff <= ~pick;
          dst_ff <= D_ADDR;
        end
        D_ADDR: if (hready) begin
          htrans_ff <= voice_pkg::HTRANS_IDLE;
          hwdata_ff <= hold_w_ff;
          dst_ff <= D_DATA;
        end
        D_DATA: if (hready) begin
          ptr_ff <= nxt_ptr == len_ff ? 16'h0 : nxt_ptr;
          hwrite_ff <= 1'b0;
          dst_ff <= D_IDLE;
        end
        default: dst_ff <= D_IDLE;
      endcase
    end
  end
  assign haddr = haddr_ff;
  assign htrans = htrans_ff;
  assign hwrite = hwrite_ff;
  assign hsize = hsize_ff;
  assign hburst = hburst_ff;
  assign hwdata = hwdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sound activity detector: SAD_RUN loud samples in a row raise the wake-up
  logic [3:0] run_ff;
  wire ssel = ctrl_ff[voice_pkg::B_SAD_SEL];
  wire sv = ctrl_ff[voice_pkg::B_SAD_EN] & ov[ssel];
  wire [15:0] spcm = opcm[ssel];
  wire [15:0] mag = spcm[15] ? 16'h0 - spcm : spcm;
  wire loud = mag > thr_ff;
  wire run_top = run_ff == 4'(voice_pkg::SAD_RUN - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= 4'h0;
      wake_ff <= 1'b0;
    end else begin
      if (sv) begin
        run_ff <= !loud ? 4'h0 : run_top ? run_ff : run_ff + 4'h1;
      end
      if (sv & loud & run_top) begin
        wake_ff <= 1'b1;
      end else if (wr_stat & pwdata[voice_pkg::B_WAKE]) begin
        wake_ff <= 1'b0;
      end
    end
  end
  assign wake_out = wake_ff;

  ////////////////////////////////////////////////////////////////////////////
  // I2S slave transmitter, fed by system DMA channel 0
  logic [15:0] tx_hold_ff, tx_sh_ff;
  logic tx_full_ff, last_ws_ff, sd_ff, req_ff;
  wire sck_fall = prev_ff[3] & ~s2_ff[3];
  wire ws_chg = s2_ff[4] != last_ws_ff;
  wire tx_load = sck_fall & ws_chg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_ff <= 16'h0;
      tx_sh_ff <= 16'h0;
      tx_full_ff <= 1'b0;
      last_ws_ff <= 1'b0;
      sd_ff <= 1'b0;
      req_ff <= 1'b0;
    end else begin
      req_ff <= ctrl_ff[voice_pkg::B_TX_EN] & ~tx_full_ff & ~system_dma_ch0_valid;
      if (sck_fall) begin
        // MSB leaves one bit clock after the word select change
        sd_ff <= tx_sh_ff[15];
        last_ws_ff <= s2_ff[4];
        tx_sh_ff <= tx_load ? (tx_full_ff ? tx_hold_ff : 16'h0) : {tx_sh_ff[14:0], 1'b0};
      end
      if (system_dma_ch0_valid) begin
        tx_hold_ff <= system_dma_ch0_data;
        tx_full_ff <= 1'b1;
      end else if (tx_load) begin
        tx_full_ff <= 1'b0;
      end
    end
  end
  assign i2s_sd_out = sd_ff;
  assign system_dma_ch0_req = req_ff;

  ////////////////////////////////////////////////////////////////////////////
  stereo_both_a: assert property (ctrl_ff[voice_pkg::B_STEREO] |-> en == 2'h3)
    else $error("stereo without both converters");
  pass_clk_a: assert property (use_ext |=> mic_clock_out == $past(s2_ff[0]))
    else $error("external clock not forwarded");
  pass_data_a: assert property (ctrl_ff[voice_pkg::B_PASS] |=>
    passthru_data_out == $past(s2_ff[1]))
    else $error("pass-through data altered");
  wake_run_a: assert property ((sv && loud && run_top) |=> wake_out)
    else $error("wake-up missed after loud run");
  apb_wait_a: assert property ((acc_req && !pready) |=> pready ##1 !pready)
    else $error("APB answer not one wait state");
  dma_seq_a: assert property ((htrans == voice_pkg::HTRANS_NONSEQ && hready)
    |=> htrans == voice_pkg::HTRANS_IDLE && hwrite && haddr[1:0] == 2'h0)
    else $error("AHB write sequence broken");
  tx_req_a: assert property ((tx_full_ff && !tx_load) |=> !system_dma_ch0_req)
    else $error("channel 0 request while buffer full");
endmodule

// >>> tb/mic_partner.sv
// Microphone and external processor clock model
`timescale 1ns/1ps
module mic_partner (
  input wire logic pt_run,
  input wire logic i2s_run,
  input wire logic level,
  output logic pt_clk,
  output logic sck,
  output logic ws,
  output logic mic_data
);
  int nfall;
  // Processor clock and I2S master clock stand still unless asked to run
  initial begin
    pt_clk = 1'b0;
    sck = 1'b0;
    ws = 1'b0;
    nfall = 0;
    #7;
    forever begin
      #80;
      if (pt_run) pt_clk = ~pt_clk;
      if (i2s_run) begin
        sck = ~sck;
        // Word select flips with a falling clock, once every 32 bit clocks
        if (!sck) begin
          if (nfall % 32 == 0) ws = ~ws;
          nfall++;
        end
      end
    end
  end
  assign mic_data = level;
endmodule

// >>> tb/tb_voice_capture_subsystem.sv
// Self-checking bench for the voice capture top
`timescale 1ns/1ps
module tb_voice_capture_subsystem;
  logic pclk, presetn, psel, penable, pwrite, hready, pt_run, level, sv, dp, e;
  logic pready, pslverr, ptc, mdi, mco, pdo, req, wake, s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, haddr, hwdata, rd, base;
  logic [1:0] htrans;
  logic [15:0] sd;
  logic [15:0] got;
  logic [2:0] hsz, hbu;
  logic i2s_run, sck, ws, sdo, hw, bck, sb;
  int errors, n_compared, cyc, n;
  logic [31:0] aq[$], dq[$];
  logic ph[$];
  voice_capture_subsystem #(.FIFO_DEPTH(4)) i_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .passthru_clock_in(ptc),
    .mic_data_in(mdi), .mic_clock_out(mco), .passthru_data_out(pdo),
    .i2s_mic_bclk_out(bck), .i2s_mic_ws_out(), .i2s_mic_sd_in(level), .i2s_sck_in(sck),
    .i2s_ws_in(ws), .i2s_sd_out(sdo), .system_dma_ch0_req(req), .system_dma_ch0_valid(sv),
    .system_dma_ch0_data(sd), .haddr(haddr), .htrans(htrans), .hwrite(hw), .hsize(hsz),
    .hburst(hbu), .hwdata(hwdata), .hready(hready), .wake_out(wake));
  mic_partner i_mic (.pt_run(pt_run), .i2s_run(i2s_run), .level(level), .pt_clk(ptc),
    .sck(sck), .ws(ws), .mic_data(mdi));
  ////////////////////////////////////////
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave's answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask
  // Bus watcher keeps the bench's own record of every write; slave stalls at random
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      test_done;
    end
    hready <= ($urandom_range(3) != 0);
    if (dp && hready) begin
      dq.push_back(hwdata);
      dp = 1'b0;
    end
    if (htrans == voice_pkg::HTRANS_NONSEQ && hready) begin
      aq.push_back(haddr);
      chk({hw, hsz, hbu}, {1'b1, voice_pkg::HSIZE_WORD, voice_pkg::HBURST_SINGLE});
      dp = 1'b1;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, sv, dp, pt_run, level, i2s_run} = 9'h0;
    {paddr, pwdata, sd} = 60'h0;
    hready = 1'b1;
    n = $urandom(32'h9514e069);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(voice_pkg::OFF_CTRL, 32'h0);
    rchk(voice_pkg::OFF_THR, 32'h400);
    apb(1'b1, 8'h1c, 32'h5);
    chk(e, 1'b1);
    apb(1'b1, voice_pkg::OFF_GAIN, 32'hffff);
    rchk(voice_pkg::OFF_GAIN, 32'h3517);
    apb(1'b1, voice_pkg::OFF_GAIN, 32'h100);
    $display("test registers done");
    apb(1'b1, voice_pkg::OFF_CTRL, 32'h1 << voice_pkg::B_PASS);
    pt_run <= 1'b1;
    repeat (100) @(posedge pclk);
    rchk(voice_pkg::OFF_STAT, 32'h8);
    for (int k = 0; k < 40; k++) begin
      @(posedge pclk);
      #1;
      ph.push_back(ptc);
      if (k >= 2) chk(mco, ph[k-2]);
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      level <= 1'($urandom_range(1));
      repeat (8) @(posedge pclk);
      chk(pdo, level);
    end
    pt_run <= 1'b0;
    repeat (120) @(posedge pclk);
    n = 0;
    s = mco;
    sb = bck;
    // Own clock: 4 toggles of each clock output in 48 cycles, bit clock counted in 16s
    for (int k = 0; k < 48; k++) begin
      @(posedge pclk);
      if (mco !== s) n++;
      if (bck !== sb) n += 16;
      s = mco;
      sb = bck;
    end
    chk(32'(n), 32'h44);
    rchk(voice_pkg::OFF_STAT, 32'h0);
    $display("test pass-through done");
    level <= 1'b1;
    base = $urandom & 32'hfffffff0;
    apb(1'b1, voice_pkg::OFF_BASE, base);
    apb(1'b1, voice_pkg::OFF_LEN, 32'h4);
    apb(1'b1, voice_pkg::OFF_CTRL, (32'h1 << voice_pkg::B_STEREO) | (32'h1 << voice_pkg::B_DMA_EN));
    while (dq.size() < 8) @(posedge pclk);
    n = 0;
    for (int k = 0; k < 8; k++) begin
      chk(aq[k], base + 32'(4 * (k % 4)));
      if (k >= 2) chk(dq[k] & 32'hfffeffff, 32'h7fff);
      if (dq[k][16] === 1'b1) n++;
    end
    chk(32'(n), 32'h4);
    $display("test dma done");
    // All-ones microphone word is -1: doubled to -2, pairs of -2 average to -2
    apb(1'b1, voice_pkg::OFF_CTRL, (32'h1 << voice_pkg::B_LEFT) |
      (32'h1 << voice_pkg::B_SRC_I2S) | (32'h1 << voice_pkg::B_DOWN) |
      (32'h1 << voice_pkg::B_SCALE) | (32'h1 << voice_pkg::B_DMA_EN));
    n = dq.size() + 4;
    while (dq.size() < n) @(posedge pclk);
    chk(dq[n-1], 32'h0000fffe);
    $display("test i2s microphone done");
    apb(1'b1, voice_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, voice_pkg::OFF_STAT, 32'h7);
    apb(1'b1, voice_pkg::OFF_CTRL, (32'h1 << voice_pkg::B_LEFT) | (32'h1 << voice_pkg::B_SAD_EN));
    repeat (3 * voice_pkg::TICK_CYC) @(posedge pclk);
    chk(wake, 1'b0);
    repeat (8 * voice_pkg::TICK_CYC) @(posedge pclk);
    chk(wake, 1'b1);
    rchk(voice_pkg::OFF_STAT, 32'h5);
    apb(1'b1, voice_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, voice_pkg::OFF_STAT, 32'h7);
    rchk(voice_pkg::OFF_STAT, 32'h0);
    chk(wake, 1'b0);
    $display("test detector done");
    apb(1'b1, voice_pkg::OFF_CTRL, 32'h1 << voice_pkg::B_TX_EN);
    repeat (4) @(posedge pclk);
    chk(req, 1'b1);
    sv <= 1'b1;
    sd <= 16'($urandom);
    @(posedge pclk);
    sv <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(req, 1'b0);
    i2s_run <= 1'b1;
    // Word select change loads the word; its MSB is sampled one bit clock later
    @(posedge ws);
    @(posedge sck);
    for (int k = 0; k < 16; k++) begin
      @(posedge sck);
      got = {got[14:0], sdo};
    end
    chk(32'(got), 32'(sd));
    $display("test slave feed done");
    test_done;
  end
endmodule
